// ===== hdl/tss_pkg.sv
package tss_pkg;
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned BURST_MS        = 1000;
    localparam int unsigned BURST_CYCLES    = CLK_HZ / 1000 * BURST_MS;
    localparam int unsigned CAP_MS          = 500;
    localparam int unsigned CAP_CYCLES      = CLK_HZ / 1000 * CAP_MS;
    localparam logic [9:0]  EMPTY_ROTATIONS = 10'd650;
    localparam logic [10:0] NEAR_END_PRINTS = 11'd1000;
    localparam logic        SRC_RIGHT       = 1'b0;
    localparam logic        SRC_LEFT        = 1'b1;
endpackage : tss_pkg

// ===== hdl/tss_burst_if.sv
// Handshake between the sequencer and each of its timers
interface tss_burst_if;
    logic start;
    logic busy;
    logic done;
    modport ctl (output start, input busy, input done);
    modport tmr (input start, output busy, output done);
endinterface : tss_burst_if

// ===== hdl/tss_timer.sv
module tss_timer
    import tss_pkg::*;
#(
    parameter int unsigned CYCLES = BURST_CYCLES
) (
    input  wire logic   clk,      // System clock
    input  wire logic   reset_n,  // Synchronous reset, low
    input  wire logic   abort,    // Cancel a running interval
    tss_burst_if.tmr    bi        // Start, busy and done
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        busy;
        logic        done;
    } tss_tmr_s;
    tss_tmr_s st_r, st_nxt;

    // Counts one interval from start, ends early on abort
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (abort) begin
            st_nxt.busy = 1'b0;
            st_nxt.cnt  = '0;
        end else if (st_r.busy) begin
            if (st_r.cnt == CYCLES - 1) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.cnt  = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 32'h1;
            end
        end else if (bi.start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bi.busy = st_r.busy;
    assign bi.done = st_r.done;
endmodule : tss_timer

// ===== hdl/tss_seq.sv
module tss_seq
    import tss_pkg::*;
#(
    parameter int unsigned BURST_LEN = BURST_CYCLES,
    parameter int unsigned CAP_LEN   = CAP_CYCLES
) (
    input  wire logic clk,              // System clock
    input  wire logic reset_n,          // Synchronous reset, low
    input  wire logic set_right,        // Right bottle locked in cradle
    input  wire logic set_left,         // Left bottle locked in cradle
    input  wire logic toner_low,        // Sub hopper reports no toner
    input  wire logic door_open,        // Toner bank door interlock open
    input  wire logic feed_req,         // Job controller requests toner feed
    input  wire logic print_done,       // One print finished, one-cycle pulse
    input  wire logic bottles_replaced, // Operator cleared empty bottles
    output logic      cap_motor_right,  // Right inner cap motor
    output logic      cap_motor_left,   // Left inner cap motor
    output logic      bottle_motor_right, // Right bottle motor
    output logic      bottle_motor_left,  // Left bottle motor
    output logic      agitator_motor,   // Sub hopper agitator motor
    output logic      feed_motor,       // Toner feed coil motor
    output logic      near_end_alert,   // Toner near-end alert
    output logic      end_alert,        // Toner end alert
    output logic      machine_stop,     // Request machine stop
    output logic      source_left       // Current source is left bottle
);
    typedef enum logic [1:0] {
        TSS_IDLE,
        TSS_BURST,
        TSS_GAP
    } tss_state_e;

    typedef struct packed {
        tss_state_e  state;
        logic        src;
        logic [1:0]  set_d;
        logic [1:0]  empty;
        logic [9:0]  rot;
        logic [10:0] prints;
        logic        near;
        logic        tend;
        logic [1:0]  cap;
        logic [1:0]  bmot;
        logic        agit;
        logic        feed;
    } tss_seq_s;

    tss_seq_s st_r, st_nxt;

    tss_burst_if burst_bi ();
    tss_burst_if cap_r_bi ();
    tss_burst_if cap_l_bi ();

    logic [1:0] set_now;
    logic [1:0] lock_edge;
    logic [1:0] cap_busy;
    logic       src_usable;

    assign set_now   = {set_left, set_right};
    assign lock_edge = set_now & ~st_r.set_d;
    assign cap_busy  = {cap_l_bi.busy, cap_r_bi.busy};

    // Selected bottle is present and not judged empty
    function automatic logic usable(input logic s, input logic [1:0] setv,
                                    input logic [1:0] emp);
        return setv[s] && !emp[s];
    endfunction : usable

    assign src_usable = usable(st_r.src, set_now, st_r.empty);

    // Timers: one burst timer, one cap opening timer per bottle
    tss_timer #(.CYCLES(BURST_LEN)) u_burst (
        .clk     (clk),
        .reset_n (reset_n),
        .abort   (door_open),
        .bi      (burst_bi.tmr)
    );
    tss_timer #(.CYCLES(CAP_LEN)) u_cap_r (
        .clk     (clk),
        .reset_n (reset_n),
        .abort   (!set_right),
        .bi      (cap_r_bi.tmr)
    );
    tss_timer #(.CYCLES(CAP_LEN)) u_cap_l (
        .clk     (clk),
        .reset_n (reset_n),
        .abort   (!set_left),
        .bi      (cap_l_bi.tmr)
    );

    // Cap opening starts on a fresh bottle lock
    assign cap_r_bi.start = lock_edge[0];
    assign cap_l_bi.start = lock_edge[1];

    // Burst starts from idle whenever the hopper is low and supply allowed
    assign burst_bi.start = (st_r.state == TSS_IDLE) && toner_low && !door_open
                            && src_usable && !st_r.tend;

    // Next-state logic for the whole sequencer
    always_comb begin
        st_nxt       = st_r;
        st_nxt.set_d = set_now;
        st_nxt.cap   = cap_busy;
        st_nxt.agit  = feed_req || (st_r.state == TSS_BURST);
        st_nxt.feed  = feed_req && !st_r.tend;

        // New bottle clears its empty mark and the rotation count
        for (int i = 0; i < 2; i++) begin
            if (lock_edge[i]) begin
                st_nxt.empty[i] = 1'b0;
            end
        end
        if (lock_edge != 2'b00 || !toner_low) begin
            st_nxt.rot = '0;
        end

        case (st_r.state)
            TSS_IDLE: begin
                if (burst_bi.start) begin
                    st_nxt.state = TSS_BURST;
                end
            end
            TSS_BURST: begin
                if (door_open) begin
                    st_nxt.state = TSS_IDLE;
                end else if (burst_bi.done) begin
                    st_nxt.state = TSS_GAP;
                    if (toner_low && lock_edge == 2'b00) begin
                        if (st_r.rot == EMPTY_ROTATIONS - 10'd1) begin
                            st_nxt.empty[st_r.src] = 1'b1;
                            st_nxt.rot             = '0;
                        end else begin
                            st_nxt.rot = st_r.rot + 10'd1;
                        end
                    end
                end
            end
            TSS_GAP: begin
                st_nxt.state = TSS_IDLE;
            end
            default: begin
                st_nxt.state = TSS_IDLE;
            end
        endcase

        // Selected bottle exhausted or absent: take the other bottle if it is usable
        if (!usable(st_r.src, set_now, st_nxt.empty) &&
            usable(!st_r.src, set_now, st_nxt.empty)) begin
            st_nxt.src = !st_r.src;
        end

        // Only the selected bottle rotates; its motor is off from the cycle after the door opens
        // Motor waits one cycle into the burst so it runs exactly the timer length
        st_nxt.bmot = 2'b00;
        if (st_r.state == TSS_BURST && st_nxt.state == TSS_BURST && !door_open) begin
            st_nxt.bmot[st_nxt.src] = 1'b1;
        end

        // Near end once no installed bottle can still supply and at least one is marked empty
        if (!st_r.near &&
            !usable(1'b0, set_now, st_nxt.empty) &&
            !usable(1'b1, set_now, st_nxt.empty) &&
            (st_nxt.empty != 2'b00)) begin
            st_nxt.near   = 1'b1;
            st_nxt.prints = '0;
        end else if (st_r.near && !st_r.tend && print_done) begin
            if (st_r.prints == NEAR_END_PRINTS - 11'd1) begin
                st_nxt.tend = 1'b1;
            end else begin
                st_nxt.prints = st_r.prints + 11'd1;
            end
        end

        // Fresh supply clears the alerts
        if (bottles_replaced || (st_r.near && (usable(1'b0, set_now, st_nxt.empty) ||
                                               usable(1'b1, set_now, st_nxt.empty)))) begin
            st_nxt.near   = 1'b0;
            st_nxt.tend   = 1'b0;
            st_nxt.prints = '0;
            if (bottles_replaced) begin
                // An empty mark set in this same cycle wins over the clear
                st_nxt.empty = st_nxt.empty & ~st_r.empty;
                st_nxt.src   = SRC_RIGHT;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r       <= '0;
            st_r.state <= TSS_IDLE;
            st_r.src   <= SRC_RIGHT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign cap_motor_right    = st_r.cap[0];
    assign cap_motor_left     = st_r.cap[1];
    assign bottle_motor_right = st_r.bmot[0];
    assign bottle_motor_left  = st_r.bmot[1];
    assign agitator_motor     = st_r.agit;
    assign feed_motor         = st_r.feed;
    assign near_end_alert     = st_r.near;
    assign end_alert          = st_r.tend;
    assign machine_stop       = st_r.tend;
    assign source_left        = st_r.src;
endmodule : tss_seq

// ===== tb/tss_seq_checker.sv
module tss_seq_checker
    import tss_pkg::*;
#(
    parameter int unsigned BURST_LEN = BURST_CYCLES,
    parameter int unsigned CAP_LEN   = CAP_CYCLES
) (
    input wire logic clk,                // Clock
    input wire logic reset_n,            // Reset, low
    input wire logic set_right,          // Lock right
    input wire logic set_left,           // Lock left
    input wire logic toner_low,          // Hopper empty
    input wire logic door_open,          // Door open
    input wire logic feed_req,           // Feed wanted
    input wire logic print_done,         // Print pulse
    input wire logic bottles_replaced,   // Clear pulse
    input wire logic cap_motor_right,    // Cap right
    input wire logic cap_motor_left,     // Cap left
    input wire logic bottle_motor_right, // Motor right
    input wire logic bottle_motor_left,  // Motor left
    input wire logic agitator_motor,     // Agitator
    input wire logic feed_motor,         // Feed coil
    input wire logic near_end_alert,     // Near end
    input wire logic end_alert,          // End
    input wire logic machine_stop,       // Stop
    input wire logic source_left         // Source
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic        run;
    logic [31:0] cnt_r;
    assign run = bottle_motor_right | bottle_motor_left;
    // Length of the current motor run
    always_ff @(posedge clk) begin
        cnt_r <= (run && reset_n) ? cnt_r + 32'h1 : 32'h0;
    end
    AST_CAP_R: assert property ($rose(set_right) |-> ##2 cap_motor_right)
        else $error("right cap motor late");
    AST_CAP_L: assert property ($rose(set_left) |-> ##2 cap_motor_left)
        else $error("left cap motor late");
    AST_ONE_MOTOR: assert property (!(bottle_motor_right && bottle_motor_left))
        else $error("both bottle motors on");
    AST_CAUSE: assert property ($rose(run) |-> $past(toner_low) && !$past(door_open))
        else $error("burst without cause");
    AST_LEN: assert property ($fell(run) |-> cnt_r == BURST_LEN || $past(door_open))
        else $error("burst length wrong");
    AST_DOOR: assert property (door_open |=> !run)
        else $error("motor on with door open");
    AST_FEED: assert property (feed_req && !end_alert && !print_done |=> feed_motor)
        else $error("feed motor off");
    AST_AGIT: assert property ($rose(run) |-> agitator_motor)
        else $error("agitator off in burst");
    AST_SIDE: assert property (run |-> bottle_motor_left == source_left)
        else $error("motor not of source");
    AST_STOP: assert property ($rose(end_alert) |-> $past(near_end_alert) && machine_stop)
        else $error("end alert wrong");
    cover property ($rose(source_left));
    cover property ($rose(near_end_alert));
    cover property ($rose(end_alert));
endmodule : tss_seq_checker

bind tss_seq tss_seq_checker #(.BURST_LEN(BURST_LEN), .CAP_LEN(CAP_LEN)) tss_seq_checker_inst (
    .clk(clk), .reset_n(reset_n), .set_right(set_right), .set_left(set_left),
    .toner_low(toner_low), .door_open(door_open), .feed_req(feed_req),
    .print_done(print_done), .bottles_replaced(bottles_replaced),
    .cap_motor_right(cap_motor_right), .cap_motor_left(cap_motor_left),
    .bottle_motor_right(bottle_motor_right), .bottle_motor_left(bottle_motor_left),
    .agitator_motor(agitator_motor), .feed_motor(feed_motor),
    .near_end_alert(near_end_alert), .end_alert(end_alert),
    .machine_stop(machine_stop), .source_left(source_left));

// ===== tb/tss_hopper_model.sv
module tss_hopper_model (
    input  wire logic clk,      // Clock
    input  wire logic drain,    // Printing empties hopper
    input  wire logic dry,      // Bottles give nothing
    input  wire logic door,     // Door open
    input  wire logic run,      // Any bottle motor on
    output logic      toner_low // Hopper empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_q = 1'b0;
    initial toner_low = 1'b0;
    // A full burst refills the hopper unless the bottle is dry
    always @(posedge clk) begin
        run_q <= run;
        if (drain) toner_low <= 1'b1;
        else if (run_q && !run && !dry && !door) toner_low <= 1'b0;
    end
endmodule : tss_hopper_model

// ===== tb/tb_top.sv
module tb_top;
    import tss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, set_right = 0, set_left = 0, door_open = 0, feed_req = 0;
    logic print_done = 0, bottles_replaced = 0, drain = 0, dry = 0, toner_low, bm_q = 0;
    logic cmr, cml, bmr, bml, agm, fdm, nea, ena, mst, srl;
    logic [9:0]  outv;
    logic [19:0] e;
    logic [19:0] q[$];
    int n_errors = 0, checks_done = 0, cyc = 0, rises = 0, rnd;
    assign outv = {cmr, cml, bmr, bml, agm, fdm, nea, ena, mst, srl};
    always #4 clk = ~clk;
    tss_seq #(.BURST_LEN(20), .CAP_LEN(10)) tss_seq_inst (.clk(clk), .reset_n(reset_n),
        .set_right(set_right), .set_left(set_left), .toner_low(toner_low),
        .door_open(door_open), .feed_req(feed_req), .print_done(print_done),
        .bottles_replaced(bottles_replaced), .cap_motor_right(cmr), .cap_motor_left(cml),
        .bottle_motor_right(bmr), .bottle_motor_left(bml), .agitator_motor(agm),
        .feed_motor(fdm), .near_end_alert(nea), .end_alert(ena), .machine_stop(mst),
        .source_left(srl));
    tss_hopper_model tss_hopper_model_inst (.clk(clk), .drain(drain), .dry(dry),
        .door(door_open), .run(bmr | bml), .toner_low(toner_low));
    task step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : step
    task chk(input logic [9:0] m, input logic [9:0] x);
        q.push_back({m, x});
        step(1);
    endtask : chk
    task cnt650;
        checks_done++;
        if (rises !== 650) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, rises, 650);
        end
        rises = 0;
    endtask : cnt650
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    // Compare masked outputs with the oldest note
    always @(negedge clk) begin
        if (q.size() > 0) begin
            e = q.pop_front();
            checks_done++;
            if ((outv & e[19:10]) !== e[9:0]) begin
                n_errors++;
                $display("wrong value at %0t: got %h expected %h", $time, outv & e[19:10], e[9:0]);
            end
        end
    end
    // Burst starts and cycle ceiling
    always @(posedge clk) begin
        if ((bmr | bml) && !bm_q) rises++;
        bm_q <= bmr | bml;
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        rnd = $urandom(32'hd7e883ce);
        step(2);
        reset_n = 1;
        chk(10'h3ff, 10'h000);
        set_right = 1;
        set_left = 1;
        step(3);
        chk(10'h300, 10'h300);
        step(11);
        chk(10'h300, 10'h000);
        feed_req = 1;
        drain = 1;
        step(1);
        drain = 0;
        step(2);
        chk(10'h0f1, 10'h0b0);
        door_open = 1;
        step(2);
        chk(10'h0d0, 10'h010);
        step(5);
        chk(10'h0c0, 10'h000);
        door_open = 0;
        step(3);
        chk(10'h080, 10'h080);
        step(40);
        chk(10'h0c0, 10'h000);
        dry = 1;
        drain = 1;
        step(1);
        drain = 0;
        rises = 0;
        for (int i = 0; i < 30000 && srl !== 1'b1; i++) step(1);
        cnt650();
        step(3);
        chk(10'h0c1, 10'h041);
        for (int i = 0; i < 30000 && nea !== 1'b1; i++) step(1);
        cnt650();
        step(30);
        chk(10'h0ce, 10'h008);
        for (int i = 0; i < 1000; i++) begin
            if (i == 999) chk(10'h006, 10'h000);
            print_done = 1;
            step(1);
            print_done = 0;
            step($urandom_range(0, 2));
        end
        step(3);
        chk(10'h016, 10'h006);
        bottles_replaced = 1;
        step(1);
        bottles_replaced = 0;
        step(3);
        chk(10'h00e, 10'h000);
        step(2);
        end_of_test();
    end
endmodule : tb_top
